/* File: hw/spp_top.sv */
// slave parallel port: 8-bit host-accessible latch with control pins
// assumes host pins asynchronous inputs, single system clock, plain reg port
//
// Operation
// - enable bit turns data port into slave port
// - host reads and writes latch independently of cpu
// - pins zero/one/two are read, write, select
// - write spans select and write strobe low
// - write end captures byte, sets event, input-full
// - read start drives latch, sets output-full
// - cpu write during read drives out, no flag
// - read end releases pins, sets event flag
// - upper control bits: full, full, overrun, enable
// - write over unread byte sets sticky overrun
// - reset clears status, control pins become inputs
//
// Added by the designer: the register offsets and strobed register access.
`include "spp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module spp_top (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_nrst,
  // register port
  input  wire logic [`SPP_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_we,
  input  wire logic                   i_re,
  output logic      [7:0]             o_rdata,
  // multi-output pwm mode of the capture/pwm unit
  input  wire logic                   i_pwm_multi_output,
  // data pins
  input  wire logic [7:0]             i_data,
  output logic      [7:0]             o_data,
  output logic      [7:0]             o_data_oe,
  // control pins, active-low host strobes in port mode
  input  wire logic [2:0]             i_ctl_pin_n,
  output logic      [2:0]             o_ctl_pin,
  output logic      [2:0]             o_ctl_pin_oe,
  // port event flag with its enable and priority
  output logic                        o_port_event_flag,
  output logic                        o_port_event_enable,
  output logic                        o_port_event_priority
);
  import spp_pkg::*;

  localparam spp_core_state_t RESET_STATE = '{
    data_in:    8'h00,
    wr_hold:    8'h00,
    writing:    1'b0,
    reading:    1'b0,
    data_latch: 8'h00,
    data_dir:   `SPP_RST_DATA_DIR,
    ctl_latch:  3'h0,
    ctl_dir:    `SPP_RST_CTL_DIR,
    in_full:    1'b0,
    out_full:   1'b0,
    overrun:    1'b0,
    port_en:    1'b0,
    event_flag: 1'b0,
    event_en:   1'b0,
    event_prio: 1'b0,
    analog_cfg: `SPP_RST_ANALOG_CFG,
    data_oe:    8'h00,
    ctl_oe:     3'h0,
    rdata:      8'h00
  };

  spp_evt_if       evt ();
  spp_core_state_t q;
  spp_core_state_t next_q;
  logic            active;
  logic            cpu_wr_data;
  logic            cpu_rd_data;
  logic            cpu_wr_status;
  logic            cpu_wr_flags;
  logic [7:0]      status_byte;

  spp_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin_n   (i_ctl_pin_n),
    .i_data    (i_data),
    .evt       (evt)
  );

  spp_seq u_seq (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .evt       (evt)
  );

  // port mode is lost while the pwm unit owns the pins in multi-output mode
  assign active          = q.port_en & ~i_pwm_multi_output;
  assign evt.port_active = active;

  always_comb begin
    next_q        = q;
    next_q.rdata  = 8'h00;
    cpu_wr_data   = i_we && (i_addr == `SPP_OFS_DATA_PORT ||
                             i_addr == `SPP_OFS_DATA_LATCH);
    cpu_rd_data   = i_re && (i_addr == `SPP_OFS_DATA_PORT) && active;
    cpu_wr_status = i_we && (i_addr == `SPP_OFS_CTL_STATUS);
    cpu_wr_flags  = i_we && (i_addr == `SPP_OFS_IRQ_FLAGS);
    status_byte   = {q.in_full, q.out_full, q.overrun, q.port_en,
                     1'b0, q.ctl_dir};

    // cpu writes; clears first so that hardware sets below win
    if (cpu_wr_data) begin
      // a cpu write shows at once on the pins where driven: during a host read, or on output bits outside port mode; never sets output-full
      next_q.data_latch = i_wdata;
      if (!q.reading) begin
        next_q.out_full = 1'b0;
      end
    end
    if (i_we) begin
      unique case (i_addr)
        `SPP_OFS_DATA_DIR: begin
          next_q.data_dir = i_wdata;
        end
        `SPP_OFS_CTL_LATCH: begin
          next_q.ctl_latch = i_wdata[2:0];
        end
        `SPP_OFS_IRQ_ENABLE: begin
          next_q.event_en = i_wdata[`SPP_BIT_PORT_EVENT];
        end
        `SPP_OFS_IRQ_PRIO: begin
          next_q.event_prio = i_wdata[`SPP_BIT_PORT_EVENT];
        end
        `SPP_OFS_ANALOG_CFG: begin
          next_q.analog_cfg = i_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    if (cpu_wr_status) begin
      // full flags are read-only; overrun is cleared only from here
      next_q.overrun = i_wdata[`SPP_BIT_OVERRUN];
      next_q.port_en = i_wdata[`SPP_BIT_PORT_EN];
      next_q.ctl_dir = i_wdata[2:0];
    end
    if (cpu_wr_flags) begin
      next_q.event_flag = i_wdata[`SPP_BIT_PORT_EVENT];
    end
    if (cpu_rd_data) begin
      next_q.in_full = 1'b0;
    end

    // cpu reads, answered on the following cycle only
    if (i_re) begin
      unique case (i_addr)
        `SPP_OFS_DATA_PORT: begin
          // port mode returns the host byte, otherwise the pin levels
          next_q.rdata = active ? q.data_in : i_data;
        end
        `SPP_OFS_DATA_LATCH: begin
          next_q.rdata = q.data_latch;
        end
        `SPP_OFS_DATA_DIR: begin
          next_q.rdata = q.data_dir;
        end
        `SPP_OFS_CTL_PORT: begin
          next_q.rdata = {5'h00, evt.pin_n};
        end
        `SPP_OFS_CTL_LATCH: begin
          next_q.rdata = {5'h00, q.ctl_latch};
        end
        `SPP_OFS_CTL_STATUS: begin
          next_q.rdata = status_byte;
        end
        `SPP_OFS_IRQ_FLAGS: begin
          next_q.rdata = {q.event_flag, 7'h00};
        end
        `SPP_OFS_IRQ_ENABLE: begin
          next_q.rdata = {q.event_en, 7'h00};
        end
        `SPP_OFS_IRQ_PRIO: begin
          next_q.rdata = {q.event_prio, 7'h00};
        end
        `SPP_OFS_ANALOG_CFG: begin
          next_q.rdata = {4'h0, q.analog_cfg};
        end
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
    end

    // host write: track the byte while strobes are low, latch on release
    if (evt.wr_begin) begin
      next_q.writing = 1'b1;
    end
    if ((evt.wr_begin || q.writing) && !evt.wr_end) begin
      next_q.wr_hold = evt.data;
    end
    if (evt.wr_end) begin
      next_q.writing    = 1'b0;
      next_q.data_in    = q.wr_hold;
      next_q.in_full    = 1'b1;
      next_q.event_flag = 1'b1;
      // byte still unread unless the cpu takes it in this very cycle
      if (q.in_full && !cpu_rd_data) begin
        next_q.overrun = 1'b1;
      end
    end

    // host read: drive latch while strobes are low
    if (evt.rd_begin) begin
      next_q.reading  = 1'b1;
      next_q.out_full = 1'b1;
    end
    if (evt.rd_end) begin
      next_q.reading    = 1'b0;
      next_q.event_flag = 1'b1;
    end
    if (!active) begin
      next_q.writing = 1'b0;
      next_q.reading = 1'b0;
    end

    // pin drivers; direction bit 1 means input
    if (active) begin
      next_q.data_oe = next_q.reading ? 8'hFF : 8'h00;
      next_q.ctl_oe  = 3'h0;
    end else begin
      next_q.data_oe = ~next_q.data_dir;
      next_q.ctl_oe  = ~next_q.ctl_dir;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  assign o_rdata               = q.rdata;
  assign o_data                = q.data_latch;
  assign o_data_oe             = q.data_oe;
  assign o_ctl_pin             = q.ctl_latch;
  assign o_ctl_pin_oe          = q.ctl_oe;
  assign o_port_event_flag     = q.event_flag;
  assign o_port_event_enable   = q.event_en;
  assign o_port_event_priority = q.event_prio;
endmodule // spp_top

`default_nettype wire

/* File: hw/spp_regs.svh */
// register offsets, field positions and reset values of the slave parallel port
// assumes an includer that lives in the same directory
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

`define SPP_ADDR_W          4
`define SPP_OFS_DATA_PORT   4'h0
`define SPP_OFS_DATA_LATCH  4'h1
`define SPP_OFS_DATA_DIR    4'h2
`define SPP_OFS_CTL_PORT    4'h3
`define SPP_OFS_CTL_LATCH   4'h4
`define SPP_OFS_CTL_STATUS  4'h5
`define SPP_OFS_IRQ_FLAGS   4'h6
`define SPP_OFS_IRQ_ENABLE  4'h7
`define SPP_OFS_IRQ_PRIO    4'h8
`define SPP_OFS_ANALOG_CFG  4'h9

`define SPP_BIT_IN_FULL     7
`define SPP_BIT_OUT_FULL    6
`define SPP_BIT_OVERRUN     5
`define SPP_BIT_PORT_EN     4
`define SPP_BIT_PORT_EVENT  7

`define SPP_PIN_RD          0
`define SPP_PIN_WR          1
`define SPP_PIN_CS          2

`define SPP_RST_DATA_DIR    8'hFF
`define SPP_RST_CTL_DIR     3'h7
`define SPP_RST_ANALOG_CFG  4'h0
`define SPP_DIGITAL_CFG     4'hA

`endif

/* File: hw/spp_pkg.sv */
// types shared by the slave parallel port modules
// assumes nothing beyond a SystemVerilog compiler
package spp_pkg;

  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_WRITING,
    SPP_READING
  } spp_xfer_t;

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [7:0] data1;
    logic [7:0] data2;
  } spp_sync_state_t;

  typedef struct packed {
    spp_xfer_t xfer;
  } spp_seq_state_t;

  typedef struct packed {
    logic [7:0] data_in;
    logic [7:0] wr_hold;
    logic       writing;
    logic       reading;
    logic [7:0] data_latch;
    logic [7:0] data_dir;
    logic [2:0] ctl_latch;
    logic [2:0] ctl_dir;
    logic       in_full;
    logic       out_full;
    logic       overrun;
    logic       port_en;
    logic       event_flag;
    logic       event_en;
    logic       event_prio;
    logic [3:0] analog_cfg;
    logic [7:0] data_oe;
    logic [2:0] ctl_oe;
    logic [7:0] rdata;
  } spp_core_state_t;

endpackage

/* File: hw/spp_evt_if.sv */
// synchronised host strobes and transfer events between the port modules
// assumes all parties run on the one system clock
`timescale 1ns/1ns
`default_nettype none

interface spp_evt_if;
  logic [2:0] pin_n;
  logic [7:0] data;
  logic       port_active;
  logic       wr_begin;
  logic       wr_end;
  logic       rd_begin;
  logic       rd_end;

  modport sync_side (output pin_n, output data);
  modport seq_side  (input pin_n, input port_active,
                     output wr_begin, output wr_end,
                     output rd_begin, output rd_end);
  modport core_side (input pin_n, input data, output port_active,
                     input wr_begin, input wr_end,
                     input rd_begin, input rd_end);
endinterface // spp_evt_if

`default_nettype wire

/* File: hw/spp_sync.sv */
// two-stage synchroniser for host strobes plus an aligned data delay
// assumes the host pins are quiet apart from their own transitions
`timescale 1ns/1ns
`default_nettype none

module spp_sync (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic [2:0] i_pin_n,
  input  wire logic [7:0] i_data,
  spp_evt_if.sync_side    evt
);
  import spp_pkg::*;

  spp_sync_state_t q;
  spp_sync_state_t next_q;

  // data delayed by the same two stages so it lines up with the strobes
  always_comb begin
    next_q        = q;
    next_q.stage1 = i_pin_n;
    next_q.stage2 = q.stage1;
    next_q.data1  = i_data;
    next_q.data2  = q.data1;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{stage1: 3'h7, stage2: 3'h7, data1: 8'h00, data2: 8'h00};
    end else begin
      q <= next_q;
    end
  end

  assign evt.pin_n = q.stage2;
  assign evt.data  = q.data2;
endmodule // spp_sync

`default_nettype wire

/* File: hw/spp_seq.sv */
// host transfer sequencer: turns synchronised strobes into begin/end events
// assumes strobes already synchronised; events are combinational pulses
`include "spp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module spp_seq (
  input  wire logic    i_clk_sys,
  input  wire logic    i_nrst,
  spp_evt_if.seq_side  evt
);
  import spp_pkg::*;

  spp_seq_state_t q;
  spp_seq_state_t next_q;
  logic           cs_low;
  logic           wr_low;
  logic           rd_low;

  always_comb begin
    next_q       = q;
    cs_low       = ~evt.pin_n[`SPP_PIN_CS];
    wr_low       = ~evt.pin_n[`SPP_PIN_WR];
    rd_low       = ~evt.pin_n[`SPP_PIN_RD];
    evt.wr_begin = 1'b0;
    evt.wr_end   = 1'b0;
    evt.rd_begin = 1'b0;
    evt.rd_end   = 1'b0;
    unique case (q.xfer)
      SPP_IDLE: begin
        // write wins if a broken host drops both strobes at once
        if (evt.port_active && cs_low && wr_low) begin
          next_q.xfer  = SPP_WRITING;
          evt.wr_begin = 1'b1;
        end else if (evt.port_active && cs_low && rd_low) begin
          next_q.xfer  = SPP_READING;
          evt.rd_begin = 1'b1;
        end
      end
      SPP_WRITING: begin
        if (!evt.port_active) begin
          next_q.xfer = SPP_IDLE;
        end else if (!cs_low || !wr_low) begin
          next_q.xfer = SPP_IDLE;
          evt.wr_end  = 1'b1;
        end
      end
      SPP_READING: begin
        if (!evt.port_active) begin
          next_q.xfer = SPP_IDLE;
        end else if (!cs_low || !rd_low) begin
          next_q.xfer = SPP_IDLE;
          evt.rd_end  = 1'b1;
        end
      end
      default: next_q.xfer = SPP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{xfer: SPP_IDLE};
    end else begin
      q <= next_q;
    end
  end
endmodule // spp_seq

`default_nettype wire

/* File: tb/spp_checker.sv */
// assertions on the slave parallel port pins and register port
// assumes binding to spp_top, one clock, async low reset
`include "spp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module spp_checker (
  input wire logic                   i_clk_sys,
  input wire logic                   i_nrst,
  input wire logic [`SPP_ADDR_W-1:0] i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_we,
  input wire logic                   i_re,
  input wire logic [7:0]             o_rdata,
  input wire logic                   i_pwm_multi_output,
  input wire logic [7:0]             i_data,
  input wire logic [7:0]             o_data,
  input wire logic [7:0]             o_data_oe,
  input wire logic [2:0]             i_ctl_pin_n,
  input wire logic [2:0]             o_ctl_pin,
  input wire logic [2:0]             o_ctl_pin_oe,
  input wire logic                   o_port_event_flag,
  input wire logic                   o_port_event_enable,
  input wire logic                   o_port_event_priority
);
  logic en;
  wire  m  = en && !i_pwm_multi_output;
  wire  rd = i_ctl_pin_n[0];
  wire  wr = i_ctl_pin_n[1];
  wire  cs = i_ctl_pin_n[2];

  // shadow of the enable bit, the mode is not visible at the pins
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      en <= 1'b0;
    end else if (i_we && i_addr == `SPP_OFS_CTL_STATUS) begin
      en <= i_wdata[4];
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  rd_start_a: assert property (m && !cs && !rd && wr && $past(cs || rd)
    |-> ##3 o_data_oe == 8'hFF) else $error("read start not driven");
  rd_end_a: assert property (m && $past(!cs && !rd && wr) && (cs || rd)
    |-> ##3 (o_data_oe == 8'h00 && o_port_event_flag))
    else $error("read end not released");
  wr_end_a: assert property (m && $past(!cs && !wr) && (cs || wr)
    |-> ##3 o_port_event_flag) else $error("write end no event");
  flag_hold_a: assert property (o_port_event_flag
    && !(i_we && i_addr == `SPP_OFS_IRQ_FLAGS) |=> o_port_event_flag)
    else $error("event flag lost");
  ctl_oe_a: assert property ($past(m) && m |-> o_ctl_pin_oe == 3'h0)
    else $error("control pins driven in port mode");
  latch_wr_a: assert property (i_we && i_addr <= `SPP_OFS_DATA_LATCH
    |=> o_data == $past(i_wdata)) else $error("latch not on pins");
  rdata_idle_a: assert property (!$past(i_re) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
  en_wr_a: assert property (i_we && i_addr == `SPP_OFS_IRQ_ENABLE
    |=> o_port_event_enable == $past(i_wdata[7]))
    else $error("enable bit not written");
  ctl_latch_a: assert property (i_we && i_addr == `SPP_OFS_CTL_LATCH
    |=> o_ctl_pin == $past(i_wdata[2:0])) else $error("ctl latch");
  prio_rd_a: assert property (i_re && i_addr == `SPP_OFS_IRQ_PRIO
    |=> o_rdata == {o_port_event_priority, 7'h00})
    else $error("priority readback");
endmodule // spp_checker

bind spp_top spp_checker chk (.*);

`default_nettype wire

/* File: tb/spp_host.sv */
// external processor model driving the host strobes and data pins
// assumes the bench resolves the shared data lines into i_bus
`timescale 1ns/1ns
`default_nettype none

module spp_host (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_bus,
  output logic      [2:0] o_pins_n,
  output logic      [7:0] o_drive
);
  initial begin
    o_pins_n = 3'h7;
    o_drive  = 8'h00;
  end

  task automatic write_byte(input logic [7:0] d);
    @(posedge i_clk_sys);
    o_pins_n <= 3'h1;
    o_drive  <= d;
    repeat (3) @(posedge i_clk_sys);
    o_pins_n <= 3'h7;
    @(posedge i_clk_sys);
    // one cycle after release the lines show the inverse, not the stale byte
    o_drive <= ~d;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic read_start(output logic [7:0] d);
    @(posedge i_clk_sys);
    o_pins_n <= 3'h2;
    repeat (3) @(posedge i_clk_sys);
    #1;
    d = i_bus;
  endtask

  task automatic read_stop();
    @(posedge i_clk_sys);
    o_pins_n <= 3'h7;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
endmodule // spp_host

`default_nettype wire

/* File: tb/tb_spp_top.sv */
// self-checking bench for the slave parallel port
// assumes spp_host as the external processor on the data pins
`include "spp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_spp_top;
  logic       clk;
  logic       nrst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic       pwm;
  logic [7:0] rdata;
  logic [7:0] dout;
  logic [7:0] doe;
  logic [2:0] pins_n;
  logic [7:0] hdrv;
  logic [7:0] bus;
  logic [7:0] got;
  logic [2:0] cpin;
  logic [2:0] coe;
  logic       flag;
  logic       fen;
  logic       fpri;
  int         fail_count;
  int         checks_done;

  assign bus = (doe & dout) | (~doe & hdrv);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  spp_top uut (
    .i_clk_sys             (clk),
    .i_nrst                (nrst),
    .i_addr                (addr),
    .i_wdata               (wdata),
    .i_we                  (we),
    .i_re                  (re),
    .o_rdata               (rdata),
    .i_pwm_multi_output    (pwm),
    .i_data                (bus),
    .o_data                (dout),
    .o_data_oe             (doe),
    .i_ctl_pin_n           (pins_n),
    .o_ctl_pin             (cpin),
    .o_ctl_pin_oe          (coe),
    .o_port_event_flag     (flag),
    .o_port_event_enable   (fen),
    .o_port_event_priority (fpri)
  );

  spp_host host (
    .i_clk_sys (clk),
    .i_bus     (bus),
    .o_pins_n  (pins_n),
    .o_drive   (hdrv)
  );

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  initial begin
    nrst  = 1'b0;
    we    = 1'b0;
    re    = 1'b0;
    pwm   = 1'b0;
    addr  = 4'h0;
    wdata = 8'h00;
    fail_count  = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(`SPP_OFS_CTL_STATUS, 8'h07);
    rd(`SPP_OFS_DATA_DIR, 8'hFF);
    rd(`SPP_OFS_IRQ_FLAGS, 8'h00);
    rd(4'hF, 8'h00);
    $display("test reset done");
    wr(`SPP_OFS_ANALOG_CFG, 8'h0A);
    rd(`SPP_OFS_ANALOG_CFG, 8'h0A);
    wr(`SPP_OFS_CTL_STATUS, 8'h17);
    rd(`SPP_OFS_CTL_STATUS, 8'h17);
    host.write_byte(8'h5A);
    rd(`SPP_OFS_IRQ_FLAGS, 8'h80);
    rd(`SPP_OFS_CTL_STATUS, 8'h97);
    rd(`SPP_OFS_DATA_PORT, 8'h5A);
    rd(`SPP_OFS_CTL_STATUS, 8'h17);
    $display("test host write done");
    host.write_byte(8'h11);
    host.write_byte(8'h22);
    rd(`SPP_OFS_CTL_STATUS, 8'hB7);
    rd(`SPP_OFS_DATA_PORT, 8'h22);
    rd(`SPP_OFS_CTL_STATUS, 8'h37);
    wr(`SPP_OFS_CTL_STATUS, 8'h17);
    rd(`SPP_OFS_CTL_STATUS, 8'h17);
    wr(`SPP_OFS_IRQ_FLAGS, 8'h00);
    rd(`SPP_OFS_IRQ_FLAGS, 8'h00);
    $display("test overrun done");
    wr(`SPP_OFS_DATA_LATCH, 8'hC3);
    host.read_start(got);
    chk("pins oe", 8'hFF, doe);
    chk("pins", 8'hC3, got);
    rd(`SPP_OFS_CTL_STATUS, 8'h57);
    rd(`SPP_OFS_IRQ_FLAGS, 8'h00);
    wr(`SPP_OFS_DATA_PORT, 8'h3C);
    @(posedge clk);
    #1;
    chk("pins", 8'h3C, bus);
    rd(`SPP_OFS_CTL_STATUS, 8'h57);
    host.read_stop();
    chk("pins oe", 8'h00, doe);
    rd(`SPP_OFS_IRQ_FLAGS, 8'h80);
    $display("test host read done");
    pwm <= 1'b1;
    host.write_byte(8'h99);
    rd(`SPP_OFS_CTL_STATUS, 8'h57);
    pwm <= 1'b0;
    wr(`SPP_OFS_CTL_STATUS, 8'h10);
    wr(`SPP_OFS_CTL_LATCH, 8'h05);
    @(posedge clk);
    #1;
    chk("ctl oe", 8'h00, {5'h00, coe});
    wr(`SPP_OFS_CTL_STATUS, 8'h00);
    @(posedge clk);
    #1;
    chk("ctl oe", 8'h07, {5'h00, coe});
    chk("ctl pin", 8'h05, {5'h00, cpin});
    wr(`SPP_OFS_IRQ_ENABLE, 8'h80);
    rd(`SPP_OFS_IRQ_ENABLE, 8'h80);
    wr(`SPP_OFS_IRQ_PRIO, 8'h80);
    rd(`SPP_OFS_IRQ_PRIO, 8'h80);
    chk("event bits", 8'h03, {6'h00, fen, fpri});
    $display("test mode and bits done");
    complete_run();
  end
endmodule // tb_spp_top

`default_nettype wire
